// *** hw/csf_acc_if.sv ***
// interface: accumulator op request and resulting flags
`timescale 1ns/1ns
`default_nettype none
interface csf_acc_if;
   logic        go;
   logic [2:0]  op;
   logic [31:0] acc;
   logic [31:0] oper;
   logic [10:0] flags;
   modport core (output go, output op, output acc, output oper,
                 input flags);
   modport alu  (input go, input op, input acc, input oper,
                 output flags);
endinterface : csf_acc_if
`default_nettype wire

// *** hw/csf_alu.sv ***
// accumulator result flag unit
`timescale 1ns/1ns
`default_nettype none
module csf_alu (
   input  wire logic core_clk_i,
   input  wire logic rstn_i,
   csf_acc_if.alu    a
);
   // flags: 0 lt,1 eq,2 gt,3 zero,4 hborrow,5 borrow,6 hcarry,
   // 7 carry,8 sign,9 overflow,10 load zero
   typedef struct packed {
      logic [10:0] flags;
   } csf_alu_s;
   csf_alu_s st_reg, st_next;
   logic [32:0] r32;
   logic [16:0] r16;
   logic [31:0] res;
   always_comb begin
      st_next = st_reg;
      r32     = 33'h0;
      r16     = 17'h0;
      res     = a.acc;
      if (a.go) begin
         case (a.op)
            csf_pkg::CSF_OP_CMP: begin
               st_next.flags[0] = $signed(a.acc) <  $signed(a.oper);
               st_next.flags[1] = a.acc == a.oper;
               st_next.flags[2] = $signed(a.acc) >  $signed(a.oper);
            end
            csf_pkg::CSF_OP_ADD: begin
               r16 = {1'b0, a.acc[15:0]} + {1'b0, a.oper[15:0]};
               st_next.flags[6] = r16[16];
               res = {16'h0, r16[15:0]};
               st_next.flags[9] = (a.acc[15] == a.oper[15]) &&
                                  (r16[15] != a.acc[15]);
            end
            csf_pkg::CSF_OP_SUB: begin
               r16 = {1'b0, a.acc[15:0]} - {1'b0, a.oper[15:0]};
               st_next.flags[4] = r16[16];
               res = {16'h0, r16[15:0]};
               st_next.flags[9] = (a.acc[15] != a.oper[15]) &&
                                  (r16[15] != a.acc[15]);
            end
            csf_pkg::CSF_OP_ADDD: begin
               r32 = {1'b0, a.acc} + {1'b0, a.oper};
               st_next.flags[7] = r32[32];
               res = r32[31:0];
               st_next.flags[9] = (a.acc[31] == a.oper[31]) &&
                                  (r32[31] != a.acc[31]);
            end
            csf_pkg::CSF_OP_SUBD: begin
               r32 = {1'b0, a.acc} - {1'b0, a.oper};
               st_next.flags[5] = r32[32];
               res = r32[31:0];
               st_next.flags[9] = (a.acc[31] != a.oper[31]) &&
                                  (r32[31] != a.acc[31]);
            end
            csf_pkg::CSF_OP_LOAD: begin
               res = a.oper;
               st_next.flags[10] = a.oper == 32'h0;
            end
            default: res = a.acc;
         endcase
         if (a.op != csf_pkg::CSF_OP_CMP &&
             a.op != csf_pkg::CSF_OP_NONE) begin
            st_next.flags[3] = res == 32'h0;
            st_next.flags[8] = res[31];
         end
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign a.flags = st_reg.flags;
endmodule : csf_alu
`default_nettype wire

// *** hw/csf_pkg.sv ***
// package: constants for the controller status flag block
package csf_pkg;
   // ----------------------------------------------------------------
   // clock and timebase half periods
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ       = 125000000;
   localparam int unsigned MIN_HALF_MS  = 30000;
   localparam int unsigned SEC_HALF_MS  = 500;
   localparam int unsigned TEN_HALF_MS  = 50;
   localparam int unsigned TWE_HALF_MS  = 25;
   localparam int unsigned MS_CYCLES    = CLK_HZ / 1000;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] EVENT_OFF  = 8'h04;
   localparam logic [7:0] MAXSC_OFF  = 8'h08;
   localparam logic [7:0] ACC_OFF    = 8'h0c;
   localparam logic [7:0] OPER_OFF   = 8'h10;
   localparam logic [7:0] STAT_OFF   = 8'h14;
   localparam logic [7:0] SYNERR_OFF = 8'h18;
   localparam logic [7:0] SCANT_OFF  = 8'h1c;

   // ctrl fields
   localparam int CTRL_MODE_LSB = 0;  // 2 bits: mode switch
   localparam int CTRL_RUN_BIT  = 2;  // processor executing
   localparam int CTRL_TEST_BIT = 3;  // test mode
   localparam int CTRL_WD_LSB   = 8;  // 16 bits watchdog limit
   // event bits (write one to trigger)
   localparam int EV_SCAN_END  = 0;
   localparam int EV_STOP      = 1;
   localparam int EV_ENI       = 2;
   localparam int EV_DISI      = 3;
   localparam int EV_SYNTAX    = 4;
   localparam int EV_TBL_OVR   = 5;
   localparam int EV_WD_KICK   = 6;
   localparam int EV_CLR_ERR   = 7;
   localparam int EV_OP_LSB    = 8;  // 3 bits: accumulator op
   localparam int EV_CODE_LSB  = 16; // 16 bits syntax code

   localparam logic [31:0] MAXSC_RST = 32'h0001_e848;
   localparam logic [15:0] WD_RST    = 16'hffff;
   localparam logic [1:0]  RESP_OK   = 2'b00;
   localparam logic [1:0]  RESP_ERR  = 2'b10;

   typedef enum logic [1:0] {
      CSF_SW_STOP = 2'h0,
      CSF_SW_RUN  = 2'h1,
      CSF_SW_TERM = 2'h2
   } csf_sw_e;

   typedef enum logic [2:0] {
      CSF_OP_NONE = 3'h0,
      CSF_OP_CMP  = 3'h1,
      CSF_OP_ADD  = 3'h2,
      CSF_OP_SUB  = 3'h3,
      CSF_OP_ADDD = 3'h4,
      CSF_OP_SUBD = 3'h5,
      CSF_OP_LOAD = 3'h6
   } csf_op_e;
endpackage : csf_pkg

// *** hw/csf_timebase.sv ***
// free-running square wave timebases
`timescale 1ns/1ns
`default_nettype none
module csf_timebase #(
   parameter int unsigned MS_CYC = csf_pkg::MS_CYCLES
) (
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   output logic [3:0]      wave_o
);
   localparam int unsigned HALF [4] = '{csf_pkg::MIN_HALF_MS,
      csf_pkg::SEC_HALF_MS, csf_pkg::TEN_HALF_MS, csf_pkg::TWE_HALF_MS};
   typedef struct packed {
      logic [16:0]      pre;
      logic [3:0][15:0] cnt;
      logic [3:0]       wave;
   } csf_tb_s;
   csf_tb_s st_reg, st_next;
   logic ms_tick;
   assign ms_tick = st_reg.pre == 17'(MS_CYC - 1);
   always_comb begin
      st_next     = st_reg;
      st_next.pre = ms_tick ? 17'h0 : st_reg.pre + 17'h1;
      for (int i = 0; i < 4; i++) begin
         if (ms_tick) begin
            if (st_reg.cnt[i] == 16'(HALF[i] - 1)) begin
               st_next.cnt[i]  = 16'h0;
               st_next.wave[i] = ~st_reg.wave[i];
            end else begin
               st_next.cnt[i] = st_reg.cnt[i] + 16'h1;
            end
         end
      end
   end
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign wave_o = st_reg.wave;
endmodule : csf_timebase
`default_nettype wire

// *** hw/csf_top.sv ***
// controller status flags with axi4-lite register access
// Function
// - first-scan flag only on first scan
// - one flag always on, one off
// - minute timebase: 30 s high, 30 s low
// - second timebase: 0.5 s each half
// - tenth-second timebase: 50 ms each half
// - twentieth-second timebase: 25 ms each half
// - alternate-scan flag toggles each scan
// - forced run: switch run and executing
// - terminal switch: run or program indication
// - test run and test stop indications
// - switch stop when switch at stop
// - instruction stop after stop instruction
// - interrupt-enabled after enable instruction
// - scan overrun when scan exceeds maximum
// - watchdog flag on watchdog expiry
// - syntax error flag plus stored code
// - table overrun on pointer out of bounds
// - compare sets exactly one relation flag
// - zero flag and load-zero flag
// - 16-bit carry and borrow flags
// - 32-bit carry and borrow flags
// - overflow on wrong sign; sign flag
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module csf_top #(
   parameter int unsigned MS_CYC = csf_pkg::MS_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      status_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;

      logic [31:0] ctrl;
      logic [31:0] maxscan;
      logic [31:0] acc;
      logic [31:0] oper;

      logic        first_scan;
      logic        alt_scan;
      logic        instr_stop;
      logic        irq_en;
      logic        scan_ovr;
      logic        wd_exp;
      logic        syn_err;
      logic [15:0] syn_code;
      logic        tbl_ovr;
      logic [31:0] scan_cnt;
      logic [31:0] last_scan;
      logic [15:0] wd_cnt;
      logic        was_run;
      logic        go;
      logic [2:0]  op;
   } csf_top_s;
   csf_top_s st_reg, st_next;

   csf_acc_if   acc_bus ();
   logic [3:0]  waves;
   logic [31:0] rd_word;
   logic [31:0] ev;
   logic        wr_fire;
   logic        running;
   logic        run_edge;
   logic        wd_fire;
   logic [1:0]  sw;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic addr_ok(input logic [7:0] ad);
      return ad[1:0] == 2'b00 && ad <= csf_pkg::SCANT_OFF;
   endfunction : addr_ok

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   csf_timebase #(.MS_CYC(MS_CYC)) u_tb (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .wave_o     (waves)
   );

   csf_alu u_alu (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .a          (acc_bus.alu)
   );
   assign acc_bus.go   = st_reg.go;
   assign acc_bus.op   = st_reg.op;
   assign acc_bus.acc  = st_reg.acc;
   assign acc_bus.oper = st_reg.oper;

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   assign sw      = st_reg.ctrl[csf_pkg::CTRL_MODE_LSB +: 2];
   assign running = st_reg.ctrl[csf_pkg::CTRL_RUN_BIT];
   always_comb begin
      status_o     = 32'h0;
      status_o[0]  = st_reg.first_scan;
      status_o[1]  = 1'b1;
      status_o[2]  = 1'b0;
      status_o[6:3] = waves;
      status_o[7]  = st_reg.alt_scan;
      status_o[8]  = sw == csf_pkg::CSF_SW_RUN && running;
      status_o[9]  = sw == csf_pkg::CSF_SW_TERM && running;
      status_o[10] = st_reg.ctrl[csf_pkg::CTRL_TEST_BIT] &&
                     running;
      status_o[11] = st_reg.ctrl[csf_pkg::CTRL_TEST_BIT] &&
                     !running;
      status_o[12] = sw == csf_pkg::CSF_SW_TERM && !running;
      status_o[13] = sw == csf_pkg::CSF_SW_STOP;
      status_o[14] = st_reg.instr_stop;
      status_o[15] = st_reg.irq_en;
      status_o[16] = st_reg.scan_ovr;
      status_o[17] = st_reg.wd_exp;
      status_o[18] = st_reg.syn_err;
      status_o[19] = st_reg.tbl_ovr;
      status_o[30:20] = acc_bus.flags;
   end

   // ----------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0;
      if (s_axi_araddr == csf_pkg::CTRL_OFF) begin
         rd_word = st_reg.ctrl;
      end else if (s_axi_araddr == csf_pkg::MAXSC_OFF) begin
         rd_word = st_reg.maxscan;
      end else if (s_axi_araddr == csf_pkg::ACC_OFF) begin
         rd_word = st_reg.acc;
      end else if (s_axi_araddr == csf_pkg::OPER_OFF) begin
         rd_word = st_reg.oper;
      end else if (s_axi_araddr == csf_pkg::STAT_OFF) begin
         rd_word = status_o;
      end else if (s_axi_araddr == csf_pkg::SYNERR_OFF) begin
         rd_word = {16'h0, st_reg.syn_code};
      end else if (s_axi_araddr == csf_pkg::SCANT_OFF) begin
         rd_word = st_reg.last_scan;
      end
   end

   // ----------------------------------------------------------------
   // bus handshake outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
   assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rresp   = st_reg.rresp;
   assign s_axi_rdata   = st_reg.rdata;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next  = st_reg;
      st_next.go = 1'b0;
      ev       = 32'h0;
      wr_fire  = 1'b0;
      run_edge = 1'b0;
      wd_fire  = 1'b0;

      // capture address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_got  = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_got  = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end

      // commit one cycle after both halves are held
      if (st_reg.aw_got && st_reg.w_got) begin
         wr_fire        = 1'b1;
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = addr_ok(st_reg.aw_addr) ?
                          csf_pkg::RESP_OK : csf_pkg::RESP_ERR;
         if (st_reg.aw_addr == csf_pkg::CTRL_OFF) begin
            st_next.ctrl = merge(st_reg.ctrl, st_reg.w_data,
                                 st_reg.w_strb);
         end else if (st_reg.aw_addr == csf_pkg::EVENT_OFF) begin
            ev = merge(32'h0, st_reg.w_data, st_reg.w_strb);
         end else if (st_reg.aw_addr == csf_pkg::MAXSC_OFF) begin
            st_next.maxscan = merge(st_reg.maxscan, st_reg.w_data,
                                    st_reg.w_strb);
         end else if (st_reg.aw_addr == csf_pkg::ACC_OFF) begin
            st_next.acc = merge(st_reg.acc, st_reg.w_data,
                                st_reg.w_strb);
         end else if (st_reg.aw_addr == csf_pkg::OPER_OFF) begin
            st_next.oper = merge(st_reg.oper, st_reg.w_data,
                                 st_reg.w_strb);
         end
      end

      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // read answer one cycle after the take
      if (s_axi_arvalid && s_axi_arready) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd_word;
         st_next.rresp  = addr_ok(s_axi_araddr) ?
                          csf_pkg::RESP_OK : csf_pkg::RESP_ERR;
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end

      // program-to-run transition restarts scan bookkeeping
      st_next.was_run = running;
      if (running && !st_reg.was_run) begin
         run_edge           = 1'b1;
         st_next.first_scan = 1'b1;
         st_next.alt_scan   = 1'b0;
         st_next.instr_stop = 1'b0;
         st_next.scan_cnt   = 32'h0;
      end else if (running) begin
         st_next.scan_cnt = st_reg.scan_cnt + 32'h1;
         if (ev[csf_pkg::EV_SCAN_END]) begin
            st_next.first_scan = 1'b0;
            st_next.alt_scan   = ~st_reg.alt_scan;
            st_next.last_scan  = st_reg.scan_cnt;
            st_next.scan_cnt   = 32'h0;
         end
      end
      if (running && st_reg.scan_cnt > st_reg.maxscan) begin
         st_next.scan_ovr = 1'b1;
      end

      // watchdog: reload on kick, expires at zero while running
      if (!running || run_edge || ev[csf_pkg::EV_WD_KICK] ||
          ev[csf_pkg::EV_SCAN_END]) begin
         st_next.wd_cnt = st_reg.ctrl[csf_pkg::CTRL_WD_LSB +: 16];
      end else if (st_reg.wd_cnt == 16'h0) begin
         wd_fire        = 1'b1;
         st_next.wd_exp = 1'b1;
      end else begin
         st_next.wd_cnt = st_reg.wd_cnt - 16'h1;
      end

      // instruction events
      if (ev[csf_pkg::EV_STOP]) begin
         st_next.instr_stop = 1'b1;
      end

      if (ev[csf_pkg::EV_ENI]) begin
         st_next.irq_en = 1'b1;
      end else if (ev[csf_pkg::EV_DISI]) begin
         st_next.irq_en = 1'b0;
      end

      if (ev[csf_pkg::EV_TBL_OVR]) begin
         st_next.tbl_ovr = 1'b1;
      end

      if (ev[csf_pkg::EV_SYNTAX]) begin
         st_next.syn_err  = 1'b1;
         st_next.syn_code = ev[csf_pkg::EV_CODE_LSB +: 16];
      end

      // accumulator op runs in the flag unit next cycle
      if (ev[csf_pkg::EV_OP_LSB +: 3] != 3'h0) begin
         st_next.go = 1'b1;
         st_next.op = ev[csf_pkg::EV_OP_LSB +: 3];
      end

      // error clear; a new event in the same cycle wins
      if (wr_fire && ev[csf_pkg::EV_CLR_ERR]) begin
         st_next.scan_ovr = running && st_reg.scan_cnt > st_reg.maxscan;
         st_next.wd_exp   = wd_fire;
         st_next.syn_err  = ev[csf_pkg::EV_SYNTAX];
         st_next.tbl_ovr  = ev[csf_pkg::EV_TBL_OVR];
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg            <= '0;
         st_reg.first_scan <= 1'b1;
         st_reg.maxscan    <= csf_pkg::MAXSC_RST;
         st_reg.ctrl       <= {8'h0, csf_pkg::WD_RST, 8'h0};
         st_reg.wd_cnt     <= csf_pkg::WD_RST;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : csf_top
`default_nettype wire

// *** tb/csf_top_props.sv ***
// checker: flag and bus relations seen at the block ports
`timescale 1ns/1ns
`default_nettype none
module csf_top_props #(
   parameter int unsigned MS_CYC = 10
) (
   input wire logic        core_clk_i,
   input wire logic        rstn_i,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] status_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_const; status_o[2:1] == 2'b01; endproperty
   a_const: assert property (p_const)
      else $error("constant flags wrong");
   property p_cmp; $onehot0(status_o[22:20]); endproperty
   a_cmp: assert property (p_cmp)
      else $error("more than one relation flag");
   property p_mode;
      $onehot0({status_o[13], status_o[12], status_o[9], status_o[8]});
   endproperty
   a_mode: assert property (p_mode)
      else $error("switch indications overlap");
   property p_test; status_o[10] |-> !status_o[11]; endproperty
   a_test: assert property (p_test)
      else $error("test run and test stop together");
   property p_scan; status_o[0] |-> !status_o[7]; endproperty
   a_scan: assert property (p_scan)
      else $error("first scan with alternate scan");
   property p_arr; s_axi_arready == !s_axi_rvalid; endproperty
   a_arr: assert property (p_arr) else $error("arready wrong");
   property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_rone: assert property (p_rone) else $error("rvalid held");
   property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_bone: assert property (p_bone) else $error("bvalid held");
   // ----------------------------------------------------------------
   // timebase half periods, first edge after reset skipped
   // ----------------------------------------------------------------
   for (genvar k = 4; k < 7; k++) begin : g_tb
      localparam int unsigned H = MS_CYC * ((k == 4) ? csf_pkg::SEC_HALF_MS
         : (k == 5) ? csf_pkg::TEN_HALF_MS : csf_pkg::TWE_HALF_MS);
      logic [31:0] cnt_reg;
      logic        prv_reg;
      logic        seen_reg;
      always_ff @(posedge core_clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            cnt_reg <= 32'h0;
            prv_reg <= 1'b0;
            seen_reg <= 1'b0;
         end else begin
            prv_reg <= status_o[k];
            seen_reg <= seen_reg | (status_o[k] != prv_reg);
            cnt_reg <= (status_o[k] != prv_reg) ? 32'h1 : cnt_reg + 32'h1;
         end
      end
      property p_tb; (status_o[k] != prv_reg) && seen_reg |-> cnt_reg == H;
      endproperty
      a_tb: assert property (p_tb)
         else $error("timebase half period wrong");
   end
endmodule : csf_top_props
`default_nettype wire

// *** tb/csf_top_test.sv ***
// testbench: bus driven checks of the status flag block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module csf_top_test;
   localparam int unsigned MSC = 10;
   logic        clk, rst_n, awv, wv, arv, awr, wrd, bv, arr, rv;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdd, st, a, b, c;
   logic [1:0]  br, rr, eb;
   logic [63:0] f;
   logic [65:0] e;
   logic [65:0] rq[$];
   logic [1:0]  bq[$];
   int          n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 13228;
   csf_top #(.MS_CYC(MSC)) i_csf_top (.core_clk_i(clk), .rstn_i(rst_n),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(1'b1), .status_o(st));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task summarize;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         summarize();
      end
   end
   // ----------------------------------------------------------------
   // result watcher: oldest note against each response
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (bv) begin
         eb = bq.pop_front();
         `CHK(br, eb)
      end
      if (rv) begin
         e = rq.pop_front();
         `CHK({rr, rdd & e[63:32]}, {e[65:64], e[31:0]})
      end
   end
   task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
      logic ha, hw, hb;
      bq.push_back(r);
      hb = 1'b0;
      awa <= ad;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      while (!hb) begin
         @(negedge clk);
         ha = awv && awr;
         hw = wv && wrd;
         hb = bv;
         @(posedge clk);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
      end
   endtask : wr
   task rd(input logic [7:0] ad, input logic [31:0] d, m,
           input logic [1:0] r);
      logic h, hr;
      rq.push_back({r, m, d & m});
      hr = 1'b0;
      ara <= ad;
      arv <= 1'b1;
      while (!hr) begin
         @(negedge clk);
         h = arv && arr;
         hr = rv;
         @(posedge clk);
         if (h) arv <= 1'b0;
      end
   endtask : rd
   task sr(input logic [31:0] d, m);
      rd(csf_pkg::STAT_OFF, d, m, csf_pkg::RESP_OK);
   endtask : sr
   task ev(input logic [31:0] d);
      wr(csf_pkg::EVENT_OFF, d, csf_pkg::RESP_OK);
   endtask : ev
   task cw(input logic [31:0] d);
      wr(csf_pkg::CTRL_OFF, d, csf_pkg::RESP_OK);
   endtask : cw
   function automatic logic [63:0] af(input int o, input logic [31:0] x, y);
      logic [32:0] s;
      logic [31:0] v, m;
      v = 32'h0;
      m = 32'h0;
      s = (o == 5) ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
      case (o)
         1: begin
            m[22:20] = 3'h7;
            v[22:20] = {$signed(x) > $signed(y), x == y,
                        $signed(x) < $signed(y)};
         end
         2: {m[26], v[26]} = {1'b1, 17'(x[15:0]) + 17'(y[15:0]) > 17'hffff};
         3: {m[24], v[24]} = {1'b1, x[15:0] < y[15:0]};
         4, 5: begin
            {m[29], m[27], m[25]} = {1'b1, o == 4, o == 5};
            {v[27], v[25]} = {o == 4 && s[32], o == 5 && s[32]};
            v[29] = ((x[31] == y[31]) == (o == 4)) && s[31] != x[31];
         end
         default: {m[30], v[30]} = {1'b1, y == 32'h0};
      endcase
      return {m, v};
   endfunction : af
   initial begin
      {rst_n, awv, wv, arv, awa, ara, wd} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      sr(32'h0000_2003, 32'hffff_ffff);
      rd(csf_pkg::CTRL_OFF, 32'h00ff_ff00, '1, csf_pkg::RESP_OK);
      rd(csf_pkg::MAXSC_OFF, csf_pkg::MAXSC_RST, '1, csf_pkg::RESP_OK);
      rd(8'h20, 32'h0, '1, csf_pkg::RESP_ERR);
      wr(8'h20, 32'h1, csf_pkg::RESP_ERR);
      wr(8'h02, 32'h1, csf_pkg::RESP_ERR);
      for (int k = 0; k < 12; k++) begin
         c = {20'h00fff, 8'hf0, 1'(k / 6), 1'((k / 3) % 2), 2'(k % 3)};
         cw(c);
         sr({18'h0, c[1:0] == 2'h0, c[1:0] == 2'h2 && !c[2], c[3] && !c[2],
             c[3] && c[2], c[1:0] == 2'h2 && c[2], c[1:0] == 2'h1 && c[2],
             8'h0}, 32'h0000_3f00);
      end
      cw(32'h00ff_ff01);
      cw(32'h00ff_ff05);
      sr(32'h1, 32'h81);
      for (int j = 1; j < 4; j++) begin
         ev(32'h1);
         sr({24'h0, 1'(j % 2), 7'h0}, 32'h81);
      end
      ev(32'h6);
      sr(32'h0000_c000, 32'h0000_c000);
      ev(32'h8);
      sr(32'h0, 32'h8000);
      a = $random(seed);
      ev({a[15:0], 16'h0030});
      sr(32'h000c_0000, 32'h000c_0000);
      rd(csf_pkg::SYNERR_OFF, {16'h0, a[15:0]}, '1, 2'h0);
      wr(csf_pkg::MAXSC_OFF, 32'h5, csf_pkg::RESP_OK);
      cw(32'h0000_1401);
      cw(32'h0000_1405);
      repeat (40) @(posedge clk);
      sr(32'h0003_0000, 32'h0003_0000);
      cw(32'h0000_1401);
      ev(32'h81);
      sr(32'h0, 32'h000f_0000);
      for (int i = 0; i < 8; i++) begin
         a = (i == 1) ? '1 : (i == 0) ? '0 : $random(seed);
         b = (i == 1) ? 32'h1 : (i == 0) ? '0 : $random(seed);
         if (i == 2) b = a;
         wr(csf_pkg::ACC_OFF, a, csf_pkg::RESP_OK);
         wr(csf_pkg::OPER_OFF, b, csf_pkg::RESP_OK);
         for (int o = 1; o < 7; o++) begin
            ev(32'(o) << 8);
            repeat (2) @(posedge clk);
            f = af(o, a, b);
            sr(f[31:0], f[63:32]);
         end
      end
      repeat (11000) @(posedge clk);
      sr(32'h0, 32'h8);
      summarize();
   end
endmodule : csf_top_test
bind csf_top csf_top_props #(.MS_CYC(MS_CYC)) i_csf_top_props (
   .core_clk_i(core_clk_i), .rstn_i(rstn_i), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .status_o(status_o));
`default_nettype wire
